// *** verilog/usr_defines.svh ***
/*
 Constants for the four-bit bidirectional universal shift register.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef USR_DEFINES_SVH
`define USR_DEFINES_SVH

`define USR_WIDTH        4
`define USR_FIFO_DEPTH   32
`define USR_FIFO_AW      5
`define USR_STAGE_RESET  4'h0
`define USR_MODE_HOLD    2'h0
`define USR_MODE_RIGHT   2'h1
`define USR_MODE_LEFT    2'h2
`define USR_MODE_LOAD    2'h3

`endif

// *** verilog/usr_pkg.sv ***
/*
 Types for the universal shift register: mode encoding and input carrier.
 Assumes usr_defines.svh is on the include path.
*/
`include "usr_defines.svh"

package usr_pkg;

    // Mode code is {mode_sel_high, mode_sel_low}
    typedef enum logic [1:0] {
        USR_HOLD  = `USR_MODE_HOLD,
        USR_RIGHT = `USR_MODE_RIGHT,
        USR_LEFT  = `USR_MODE_LEFT,
        USR_LOAD  = `USR_MODE_LOAD
    } usr_mode_e;

    typedef struct packed {
        logic                    mode_sel_high;
        logic                    mode_sel_low;
        logic                    ser_left;
        logic                    ser_right;
        logic [`USR_WIDTH-1:0]   par_data;
    } usr_ctl_s;

endpackage : usr_pkg

// *** verilog/usr_shift_reg.sv ***
/*
 Four-bit bidirectional universal shift register with a snapshot FIFO.
 Assumes mode, serial and parallel inputs are synchronous to sys_clk_i.
*/
//
// Summary of operation
// - Clear low forces all four stages low at once, independent of clock.
// - Clear high, both mode selects high: load parallel inputs on rising edge.
// - Parallel load takes all four bits together, each into its own stage.
// - Serial inputs are ignored during a parallel load.
// - Apart from clear, stage contents change only on a rising clock edge.
// - Low select high, high select low: shift right each rising edge.
// - Right shift: stage0 takes right serial input, others take lower neighbour.
// - Low select low, high select high: shift left each rising edge.
// - Left shift: stage3 takes left serial input, others take higher neighbour.
// - Both mode selects low: clock edges ignored, stages unchanged.
// - Clear high and no rising edge: every output keeps its previous level.
// - All four stages are presented continuously on parallel outputs.
`timescale 1ns/10ps
`include "usr_defines.svh"

// ==========================================================================
// Snapshot FIFO
module usr_fifo #(
    parameter int WIDTH = `USR_WIDTH,
    parameter int DEPTH = `USR_FIFO_DEPTH,
    parameter int AW    = `USR_FIFO_AW
) (
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             ready_reg;
    logic             push;
    logic             pop;

    assign push       = in_valid_i && ready_reg;
    // Output stage refills when empty or being drained
    assign pop        = (count_reg != '0) && (!out_valid_o || out_ready_i);
    // Ready has a flop of its own so the top output leaves straight from a register
    assign in_ready_o = ready_reg;

    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
            count_next = count_reg + (AW+1)'(1);
        else if (pop && !push)
            count_next = count_reg - (AW+1)'(1);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            count_reg <= count_next;
            ready_reg <= (count_next != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end
        else if (pop)
        begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem_reg[rd_ptr_reg];
        end
        else if (out_ready_i)
            out_valid_o <= 1'b0;
    end

    // ======================================================================
    // Stream checks
    property p_fifo_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o));
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("snapshot changed while stalled");

    property p_fifo_bound;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        count_reg <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");
endmodule : usr_fifo

// ==========================================================================
// Shift register top
module usr_shift_reg
    import usr_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  clear_n_i,
    input  wire usr_ctl_s              ctl_i,
    output logic                       stage0_out_o,
    output logic                       stage1_out_o,
    output logic                       stage2_out_o,
    output logic                       stage3_out_o,
    output logic                       snap_in_ready_o,
    output logic                       snap_valid_o,
    input  wire logic                  snap_ready_i,
    output logic [`USR_WIDTH-1:0]      snap_data_o
);
    logic [`USR_WIDTH-1:0] stage_reg;
    logic [`USR_WIDTH-1:0] stage_next;
    usr_mode_e             mode;
    logic                  snap_push;

    assign mode = usr_mode_e'({ctl_i.mode_sel_high, ctl_i.mode_sel_low});

    // ======================================================================
    // Next stage value
    always_comb
    begin
        stage_next = stage_reg;
        unique case (mode)
            USR_HOLD:  stage_next = stage_reg;
            USR_RIGHT: stage_next = {stage_reg[2:0], ctl_i.ser_right};
            USR_LEFT:  stage_next = {ctl_i.ser_left, stage_reg[3:1]};
            USR_LOAD:  stage_next = ctl_i.par_data;
        endcase
    end

    // ======================================================================
    // Stage flops; clear acts without the clock, so it stays a direct override
    always_ff @(posedge sys_clk_i or negedge clear_n_i)
    begin
        if (!clear_n_i)
            stage_reg <= `USR_STAGE_RESET;
        else if (sys_rst_i)
            stage_reg <= `USR_STAGE_RESET;
        else
            stage_reg <= stage_next;
    end

    assign stage0_out_o = stage_reg[0];
    assign stage1_out_o = stage_reg[1];
    assign stage2_out_o = stage_reg[2];
    assign stage3_out_o = stage_reg[3];

    // ======================================================================
    // Snapshot stream: every load or shift pushes the new contents.
    // A full FIFO drops snapshots rather than stall the register itself.
    assign snap_push = clear_n_i && !sys_rst_i && (mode != USR_HOLD);

    usr_fifo #(
        .WIDTH (`USR_WIDTH),
        .DEPTH (`USR_FIFO_DEPTH),
        .AW    (`USR_FIFO_AW)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (snap_push),
        .in_ready_o  (snap_in_ready_o),
        .in_data_i   (stage_next),
        .out_valid_o (snap_valid_o),
        .out_ready_i (snap_ready_i),
        .out_data_o  (snap_data_o)
    );

    // ======================================================================
    // Assertions
    property p_clear;
        @(posedge sys_clk_i) !clear_n_i |-> stage_reg == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero stages");

    property p_clear_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !clear_n_i |=> stage_reg == 4'h0;
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("edge acted under clear");

    property p_load;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_LOAD) |=> (!clear_n_i || stage_reg == $past(ctl_i.par_data));
    endproperty
    a_load: assert property (p_load) else $error("parallel load wrong");

    property p_load_ends;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_LOAD) |=> (!clear_n_i
            || (stage_reg[0] == $past(ctl_i.par_data[0])
                && stage_reg[3] == $past(ctl_i.par_data[3])));
    endproperty
    a_load_ends: assert property (p_load_ends) else $error("serial data entered on load");

    property p_right;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_RIGHT) |=> (!clear_n_i
            || stage_reg == {$past(stage_reg[2:0]), $past(ctl_i.ser_right)});
    endproperty
    a_right: assert property (p_right) else $error("right shift wrong");

    property p_left;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_LEFT) |=> (!clear_n_i
            || stage_reg == {$past(ctl_i.ser_left), $past(stage_reg[3:1])});
    endproperty
    a_left: assert property (p_left) else $error("left shift wrong");

    property p_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_HOLD) ##1 clear_n_i |-> $stable(stage_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("hold changed stages");

    property p_change_cause;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(stage_reg) |-> ($past(mode) != USR_HOLD || stage_reg == 4'h0);
    endproperty
    a_change_cause: assert property (p_change_cause) else $error("stage changed without op");

    property p_outputs;
        @(posedge sys_clk_i)
        {stage3_out_o, stage2_out_o, stage1_out_o, stage0_out_o} == stage_reg;
    endproperty
    a_outputs: assert property (p_outputs) else $error("outputs differ from stages");

    property p_right_entry;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_RIGHT) |=> (!clear_n_i
            || stage0_out_o == $past(ctl_i.ser_right));
    endproperty
    a_right_entry: assert property (p_right_entry) else $error("right serial bit lost");

    property p_left_entry;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_LEFT) |=> (!clear_n_i
            || stage3_out_o == $past(ctl_i.ser_left));
    endproperty
    a_left_entry: assert property (p_left_entry) else $error("left serial bit lost");

    property p_load_pins;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && mode == USR_LOAD) |=> (!clear_n_i
            || {stage3_out_o, stage2_out_o, stage1_out_o, stage0_out_o} == $past(ctl_i.par_data));
    endproperty
    a_load_pins: assert property (p_load_pins) else $error("load bits misplaced");

    property p_clear_pins;
        @(posedge sys_clk_i)
        !clear_n_i |-> {stage3_out_o, stage2_out_o, stage1_out_o, stage0_out_o} == `USR_STAGE_RESET;
    endproperty
    a_clear_pins: assert property (p_clear_pins) else $error("outputs high under clear");

    property p_no_push_in_clear;
        @(posedge sys_clk_i)
        !clear_n_i |-> !snap_push;
    endproperty
    a_no_push_in_clear: assert property (p_no_push_in_clear) else $error("snapshot under clear");

    // ======================================================================
    // Shadow of the contents for the long-hold check; a run of hold edges can
    // last far longer than a sequence may count, so it is counted here
    logic [`USR_WIDTH-1:0] hold_val_reg;
    logic [7:0]            hold_run_reg;

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || !clear_n_i)
        begin
            hold_val_reg <= `USR_STAGE_RESET;
            hold_run_reg <= 8'h00;
        end
        else if (mode != USR_HOLD)
        begin
            hold_val_reg <= stage_next;
            hold_run_reg <= 8'h00;
        end
        else if (hold_run_reg != 8'hFF)
            hold_run_reg <= hold_run_reg + 8'h01;
    end

    property p_hold_run;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (clear_n_i && hold_run_reg != 8'h00) |-> stage_reg == hold_val_reg;
    endproperty
    a_hold_run: assert property (p_hold_run) else $error("contents drifted during hold");
endmodule : usr_shift_reg

// *** test/usr_snap_sink.sv ***
/*
 Consumer model for the snapshot stream of the shift register.
 Assumes stall and pace controls come from the bench on the same clock.
*/
`timescale 1ns/10ps
`include "usr_defines.svh"

module usr_snap_sink (
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  stall_i,
    input  wire logic                  slow_i,
    input  wire logic                  snap_valid_i,
    input  wire logic [`USR_WIDTH-1:0] snap_data_i,
    output logic                       snap_ready_o
);
    logic [`USR_WIDTH-1:0] rx_q[$];

    // ======================================================================
    // Accept pattern: slow pace takes a word only every other cycle
    always @(posedge sys_clk_i)
    begin
        if (!sys_rst_i && snap_valid_i && snap_ready_o)
            rx_q.push_back(snap_data_i);
        if (sys_rst_i)
            snap_ready_o <= 1'b0;
        else
            snap_ready_o <= !stall_i && (!slow_i || !snap_ready_o);
    end
endmodule : usr_snap_sink

// *** test/tb_top.sv ***
/*
 Self-checking bench for the universal shift register and its snapshot FIFO.
 Assumes the design files and the consumer model are compiled first.
*/
`timescale 1ns/10ps
`include "usr_defines.svh"
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); end end

module tb_top
    import usr_pkg::*;
;
    logic                  sys_clk_i;
    logic                  sys_rst_i;
    logic                  clear_n_i;
    usr_ctl_s              ctl_i;
    logic                  s0, s1, s2, s3, in_rdy, snap_valid, snap_ready, stall, slow;
    logic [`USR_WIDTH-1:0] snap_data, stages, exp_reg;
    int                    err_total = 0;
    int                    num_checks = 0;
    int                    cyc = 0;

    assign stages = {s3, s2, s1, s0};

    usr_shift_reg dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clear_n_i(clear_n_i),
        .ctl_i(ctl_i), .stage0_out_o(s0), .stage1_out_o(s1), .stage2_out_o(s2),
        .stage3_out_o(s3), .snap_in_ready_o(in_rdy), .snap_valid_o(snap_valid),
        .snap_ready_i(snap_ready), .snap_data_o(snap_data));

    usr_snap_sink sink (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
        .slow_i(slow), .snap_valid_i(snap_valid), .snap_data_i(snap_data),
        .snap_ready_o(snap_ready));

    // ======================================================================
    // Reference stages; clear acts at once, not on the clock
    always @(posedge sys_clk_i or negedge clear_n_i)
    begin
        if (!clear_n_i || sys_rst_i)
            exp_reg <= 4'h0;
        else
            case (usr_mode_e'({ctl_i.mode_sel_high, ctl_i.mode_sel_low}))
                USR_RIGHT: exp_reg <= {exp_reg[2:0], ctl_i.ser_right};
                USR_LEFT:  exp_reg <= {ctl_i.ser_left, exp_reg[3:1]};
                USR_LOAD:  exp_reg <= ctl_i.par_data;
                default:   exp_reg <= exp_reg;
            endcase
    end

    always @(negedge sys_clk_i)
        `CHK("stages", exp_reg, stages)

    // ======================================================================
    // Clock, timeout and verdict
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up;
    begin
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask : wrap_up

    // ======================================================================
    // One operation, then a hold edge; mode moves while clock is high, except for the load that t_clear issues under clear
    task automatic put(input usr_mode_e m, input logic sl, input logic sr,
                       input logic [3:0] d, input logic [3:0] ex);
    begin
        ctl_i <= '{m[1], m[0], sl, sr, d};
        @(posedge sys_clk_i);
        ctl_i.mode_sel_high <= 1'b0;
        ctl_i.mode_sel_low  <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("op", ex, stages)
        @(posedge sys_clk_i);
    end
    endtask : put

    task automatic t_walk;
    begin
        put(USR_LOAD, 1'b0, 1'b0, 4'hA, 4'hA);
        put(USR_RIGHT, 1'b0, 1'b1, 4'h0, 4'h5);
        put(USR_HOLD, 1'b1, 1'b1, 4'hF, 4'h5);
        put(USR_LOAD, 1'b1, 1'b1, 4'h0, 4'h0);
        put(USR_LEFT, 1'b1, 1'b0, 4'hF, 4'h8);
        put(USR_LEFT, 1'b0, 1'b1, 4'hF, 4'h4);
        put(USR_RIGHT, 1'b1, 1'b0, 4'hF, 4'h8);
    end
    endtask : t_walk

    // Clear lands mid-cycle; loads are refused until it lifts
    task automatic t_clear;
    begin
        put(USR_LOAD, 1'b0, 1'b0, 4'hF, 4'hF);
        @(negedge sys_clk_i);
        clear_n_i <= 1'b0;
        #1;
        `CHK("clear", 4'h0, stages)
        put(USR_LOAD, 1'b0, 1'b0, 4'h9, 4'h0);
        clear_n_i <= 1'b1;
        put(USR_LOAD, 1'b0, 1'b0, 4'h6, 4'h6);
    end
    endtask : t_clear

    // Full FIFO drops words, so only the first 33 loads come back
    task automatic t_fifo;
        int          k;
        logic [31:0] seq;
    begin
        repeat (8) @(posedge sys_clk_i);
        // Every load and shift of the earlier scenarios came back in order, none from under clear
        `CHK("snaps", 8, sink.rx_q.size())
        seq = {sink.rx_q[0], sink.rx_q[1], sink.rx_q[2], sink.rx_q[3],
               sink.rx_q[4], sink.rx_q[5], sink.rx_q[6], sink.rx_q[7]};
        `CHK("snap_seq", 32'hA50848F6, seq)
        sink.rx_q.delete();
        stall <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            ctl_i <= '{1'b1, 1'b1, 1'b0, 1'b0, k[3:0]};
            @(posedge sys_clk_i);
        end
        ctl_i <= '0;
        @(negedge sys_clk_i);
        `CHK("full", 1'b0, in_rdy)
        slow  <= 1'b1;
        stall <= 1'b0;
        repeat (100) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK("count", 33, sink.rx_q.size())
        `CHK("empty", 1'b0, snap_valid)
        `CHK("ready", 1'b1, in_rdy)
        for (k = 0; k < 33 && k < sink.rx_q.size(); k++)
            `CHK("word", k[3:0], sink.rx_q[k])
    end
    endtask : t_fifo

    initial
    begin
        sys_rst_i = 1'b1;
        clear_n_i = 1'b1;
        ctl_i     = '0;
        stall     = 1'b0;
        slow      = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("rst_valid", 1'b0, snap_valid)
        `CHK("rst_ready", 1'b1, in_rdy)
        @(posedge sys_clk_i);
        t_walk();
        t_clear();
        t_fifo();
        wrap_up();
    end
endmodule : tb_top
